// ==== hdl/fwc_defs.svh ====
// register offsets, field widths and reset values of the window bank
`ifndef FWC_DEFS_SVH
`define FWC_DEFS_SVH
`define FWC_ADDR_W        8
`define FWC_DATA_W        8
`define FWC_OFF_SRC_X_LO  8'hD0
`define FWC_OFF_SRC_X_HI  8'hD1
`define FWC_OFF_SRC_Y_LO  8'hD2
`define FWC_OFF_SRC_Y_HI  8'hD3
`define FWC_OFF_WIDTH_LO  8'hD4
`define FWC_OFF_WIDTH_HI  8'hD5
`define FWC_OFF_HEIGHT_LO 8'hD6
`define FWC_OFF_HEIGHT_HI 8'hD7
`define FWC_OFF_SCR_X_LO  8'hD8
`define FWC_OFF_SCR_X_HI  8'hD9
`define FWC_OFF_SCR_Y_LO  8'hDA
`define FWC_OFF_SCR_Y_HI  8'hDB
`define FWC_NUM_REGS      12
`define FWC_X_W           10
`define FWC_Y_W           9
`define FWC_RESET_VAL     8'h00
`define FWC_HI_MASK_X     8'h03
`define FWC_HI_MASK_Y     8'h01
`define FWC_LO_MASK       8'hFF
`endif

// ==== hdl/fwc_pkg.sv ====
// types shared by the window bank
package fwc_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fwc_req_t;

    typedef struct packed {
        logic [9:0] src_x;
        logic [8:0] src_y;
        logic [9:0] width;
        logic [9:0] height;
        logic [9:0] scr_x;
        logic [8:0] scr_y;
    } fwc_cfg_t;
endpackage

// ==== hdl/fwc_byte_reg.sv ====
// one byte register with a writable bit mask
`timescale 1ns/1ps
`include "fwc_defs.svh"
module fwc_byte_reg #(
    parameter logic [7:0] MASK = 8'hFF
) (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       we,
    input  wire logic [7:0] wdata,
    output logic      [7:0] q
);
    logic [7:0] q_r;
    logic [7:0] q_nxt;

    // reserved bits never take written ones
    assign q_nxt = we ? (wdata & MASK) : q_r;
    assign q     = q_r;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            q_r <= `FWC_RESET_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule

// ==== hdl/fwc_regs.sv ====
// floating window configuration bank behind the host byte port
// What this block does
// - source x start bits 7-0 in a read-write byte, reset zero
// - source x start bits 9-8 in high byte bits 1-0, rest read zero
// - source y start bits 7-0 in a read-write byte, reset zero
// - source y start bit 8 in high byte bit 0, bits 7-1 read zero
// - width bits 7-0 in a read-write byte, reset zero
// - width bits 9-8 in high byte bits 1-0, rest read zero
// - height bits 7-0 in a read-write byte, reset zero
// - height bits 9-8 in high byte bits 1-0, rest read zero
// - screen x position bits 7-0 in a read-write byte, reset zero
// - screen x bits 9-8 in high byte bits 1-0, rest read zero
// - screen y position bits 7-0 in a read-write byte, reset zero
// - screen y bit 8 in high byte bit 0, bits 7-1 read zero
`timescale 1ns/1ps
`include "fwc_defs.svh"
module fwc_regs (
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    input  wire fwc_pkg::fwc_req_t  req,
    output logic      [7:0]         rdata,
    output logic                    rvalid,
    output logic                    hit,
    output fwc_pkg::fwc_cfg_t       cfg
);
    localparam int N = `FWC_NUM_REGS;

    // writable masks per index; odd indices are high bytes
    localparam logic [7:0] MASKS [N] = '{
        `FWC_LO_MASK, `FWC_HI_MASK_X,
        `FWC_LO_MASK, `FWC_HI_MASK_Y,
        `FWC_LO_MASK, `FWC_HI_MASK_X,
        `FWC_LO_MASK, `FWC_HI_MASK_X,
        `FWC_LO_MASK, `FWC_HI_MASK_X,
        `FWC_LO_MASK, `FWC_HI_MASK_Y
    };

    logic [7:0] offs;
    logic       in_range;
    logic [3:0] idx;
    logic [7:0] q [N];
    logic [7:0] rd_sel;
    logic [7:0] rdata_r;
    logic       rvalid_r;
    logic       hit_r;
    fwc_pkg::fwc_cfg_t cfg_r;
    fwc_pkg::fwc_cfg_t cfg_nxt;

    // address decode
    assign offs     = req.addr - `FWC_OFF_SRC_X_LO;
    assign in_range = (req.addr >= `FWC_OFF_SRC_X_LO)
                    && (req.addr <= `FWC_OFF_SCR_Y_HI);
    assign idx      = offs[3:0];

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_reg
            logic we_g;
            assign we_g = req.wr && in_range && (idx == 4'(g));
            // storage per byte; mask drops reserved bits
            fwc_byte_reg #(
                .MASK (MASKS[g])
            ) u_reg (
                .clk_sys (clk_sys),
                .rstn    (rstn),
                .we      (we_g),
                .wdata   (req.wdata),
                .q       (q[g])
            );
        end
    endgenerate

    // read mux; reserved bits come back zero from storage
    assign rd_sel = in_range ? q[idx] : `FWC_RESET_VAL;

    // geometry fields joined from byte pairs
    assign cfg_nxt.src_x  = {q[1][1:0], q[0]};
    assign cfg_nxt.src_y  = {q[3][0], q[2]};
    assign cfg_nxt.width  = {q[5][1:0], q[4]};
    assign cfg_nxt.height = {q[7][1:0], q[6]};
    assign cfg_nxt.scr_x  = {q[9][1:0], q[8]};
    assign cfg_nxt.scr_y  = {q[11][0], q[10]};

    assign rdata  = rdata_r;
    assign rvalid = rvalid_r;
    assign hit    = hit_r;
    assign cfg    = cfg_r;

    // read answer registered one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
            hit_r    <= 1'b0;
        end else begin
            rdata_r  <= req.rd ? rd_sel : 8'h00;
            rvalid_r <= req.rd;
            hit_r    <= (req.rd || req.wr) && in_range;
        end
    end

    // geometry to the display logic
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cfg_r <= '0;
        end else begin
            cfg_r <= cfg_nxt;
        end
    end
endmodule

// ==== tb/fwc_regs_sva.sv ====
// checker for the window bank ports
`timescale 1ns/1ps
module fwc_regs_sva (
    input wire logic              clk_sys,
    input wire logic              rstn,
    input wire fwc_pkg::fwc_req_t req,
    input wire logic [7:0]        rdata,
    input wire logic              rvalid,
    input wire logic              hit,
    input wire fwc_pkg::fwc_cfg_t cfg
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_wr(a);
        req.wr && req.addr == a ##1 !(req.wr && req.addr == a);
    endsequence
    AST_RDV: assert property (req.rd |=> rvalid)
        else $error("no read answer");
    AST_HIT: assert property ((req.rd || req.wr) &&
        req.addr inside {[8'hD0:8'hDB]} |=> hit) else $error("no hit");
    AST_UNM: assert property ((req.rd || req.wr) &&
        !(req.addr inside {[8'hD0:8'hDB]}) |=> !hit && rdata == 8'h00)
        else $error("unmapped answered");
    AST_XLO: assert property (s_wr(8'hD0) |=>
        cfg.src_x[7:0] == $past(req.wdata, 2)) else $error("src x low");
    AST_WHI: assert property (s_wr(8'hD5) |=>
        {6'h00, cfg.width[9:8]} == ($past(req.wdata, 2) & 8'h03))
        else $error("width high");
    AST_XHI: assert property (rvalid && $past(req.addr) == 8'hD1 |->
        rdata[7:2] == 6'h00) else $error("src x high reserved");
    AST_YHI: assert property (rvalid && $past(req.addr) == 8'hD3 |->
        rdata[7:1] == 7'h00) else $error("src y high reserved");
    AST_STB: assert property (!req.wr ##1 !req.wr |=> $stable(cfg))
        else $error("cfg moved");
endmodule
bind fwc_regs fwc_regs_sva fwc_regs_sva_i (.clk_sys(clk_sys), .rstn(rstn),
    .req(req), .rdata(rdata), .rvalid(rvalid), .hit(hit), .cfg(cfg));

// ==== tb/testbench.sv ====
// testbench for the window bank
`timescale 1ns/1ps
module testbench;
    logic              clk_sys = 1'b0;
    logic              rstn    = 1'b0;
    fwc_pkg::fwc_req_t req     = '0;
    logic [7:0]        rdata;
    logic              rvalid;
    logic              hit;
    fwc_pkg::fwc_cfg_t cfg;
    int                error_cnt = 0;
    int                compares  = 0;
    int                cyc       = 0;
    always #20 clk_sys = ~clk_sys;
    fwc_regs fwc_regs_i (.clk_sys(clk_sys), .rstn(rstn), .req(req),
        .rdata(rdata), .rvalid(rvalid), .hit(hit), .cfg(cfg));
    task automatic chk(string n, logic [63:0] s, logic [63:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(logic w, logic r, logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys);
        req <= '{w, r, a, d};
        @(posedge clk_sys);
        req <= '0;
        #1;
    endtask
    function automatic logic [7:0] em(logic [7:0] a);
        return (a == 8'hD3 || a == 8'hDB) ? 8'h01 : (a[0] ? 8'h03 : 8'hFF);
    endfunction
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            acc(0, 1, 8'(8'hD0 + i), 8'h00);
            chk("reset", {rvalid, hit, rdata}, 10'h300);
        end
        $display("test reset values done");
        for (int i = 0; i < 12; i++) begin
            acc(1, 0, 8'(8'hD0 + i), 8'hFF);
            acc(0, 1, 8'(8'hD0 + i), 8'h00);
            chk("mask", rdata, em(8'(8'hD0 + i)));
        end
        chk("cfg ones", cfg, {58{1'b1}});
        acc(1, 0, 8'hD4, 8'h5A);
        acc(0, 1, 8'hD4, 8'h00);
        chk("width", {rdata, cfg.width}, {8'h5A, 10'h35A});
        $display("test masks done");
        for (int i = 0; i < 2; i++) begin
            acc(1, 0, i ? 8'hDC : 8'hCF, 8'hFF);
            chk("unmap wr", hit, 1'b0);
            acc(0, 1, i ? 8'hDC : 8'hCF, 8'h00);
            chk("unmap rd", {hit, rdata}, 9'h000);
        end
        chk("cfg kept", cfg.width, 10'h35A);
        $display("test unmapped done");
        for (int i = 0; i < 12; i++) begin
            acc(1, 0, 8'(8'hD0 + i), 8'(8'hA0 + i));
        end
        @(posedge clk_sys);
        #1;
        chk("geom", cfg, {10'h1A0, 9'h1A2, 10'h1A4, 10'h3A6, 10'h1A8, 9'h1AA});
        $display("test geometry done");
        @(posedge clk_sys);
        rstn <= 1'b0;
        @(posedge clk_sys);
        rstn <= 1'b1;
        acc(0, 1, 8'hD1, 8'h00);
        chk("rerst cfg", cfg, 58'h0);
        chk("rerst rd", rdata, 8'h00);
        $display("test second reset done");
        end_sim();
    end
endmodule
